// File: afpg_top.sv
// four 8-bit port gpio with strobe-timed peripheral register access
// assumes: bridge holds select, address and write steady around the strobe,
// pad cells resolve the pins, all inputs synchronous to sys_clk
`timescale 1ns/1ps
`include "afpg_map.svh"
module afpg_top (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic power_on_reset_n,
  input wire logic psel,
  input wire logic pstb,
  input wire logic pwrite,
  input wire logic [6:2] paddr,
  input wire logic [7:0] pdata_in,
  output logic [7:0] pdata_out,
  output logic pdata_oe,
  output logic [7:0] port_a_out_lines,
  output logic [7:0] port_a_drive_en_n,
  input wire logic [7:0] port_a_in_lines,
  output logic [7:0] port_b_out_lines,
  output logic [7:0] port_b_drive_en_n,
  input wire logic [7:0] port_b_in_lines,
  output logic [7:0] port_c_out_lines,
  output logic [7:0] port_c_drive_en_n,
  input wire logic [7:0] port_c_in_lines,
  output logic [7:0] port_d_out_lines,
  output logic [7:0] port_d_drive_en_n,
  input wire logic [7:0] port_d_in_lines,
  output logic port_a_irq,
  output logic port_b_irq,
  output logic port_c_irq,
  output logic port_d_irq
);
  // port number of a word index
  function automatic afpg_pkg::afpg_port_t idx_port(input afpg_pkg::afpg_index_t idx);
    idx_port = idx[4:3];
  endfunction

  // field of a word index
  function automatic afpg_pkg::afpg_field_t idx_field(input afpg_pkg::afpg_index_t idx);
    idx_field = idx[2:0];
  endfunction

  // mask of the bits of a port that are shared with other functions
  function automatic afpg_pkg::afpg_byte_t alt_bits(input afpg_pkg::afpg_port_t p);
    unique case (p)
      `AFPG_PORT_B: alt_bits = `AFPG_ALT_MASK_B;
      `AFPG_PORT_D: alt_bits = `AFPG_ALT_MASK_D;
      default: alt_bits = 8'h00;
    endcase
  endfunction

  logic rst;
  logic pstb_q;
  logic wr_take;
  afpg_pkg::afpg_port_t acc_port;
  afpg_pkg::afpg_field_t acc_field;
  afpg_pkg::afpg_byte_t data_q [4];
  afpg_pkg::afpg_byte_t dir_q [4];
  afpg_pkg::afpg_byte_t mask_q [4];
  afpg_pkg::afpg_byte_t edge_q [4];
  afpg_pkg::afpg_byte_t pol_q [4];
  afpg_pkg::afpg_byte_t clr_q [4];
  afpg_pkg::afpg_byte_t alt_q [4];
  afpg_pkg::afpg_byte_t pin_s1 [4];
  afpg_pkg::afpg_byte_t pin_s2 [4];
  afpg_pkg::afpg_byte_t pin_raw [4];
  afpg_pkg::afpg_byte_t stat [4];
  afpg_pkg::afpg_byte_t gpio_sel [4];
  afpg_pkg::afpg_byte_t out_q [4];
  afpg_pkg::afpg_byte_t oen_q [4];
  logic [3:0] irq_w;
  logic [3:0] irq_q;
  afpg_pkg::afpg_byte_t next_rdata;

  // either reset source returns the block to its reset state
  assign rst = srst | ~power_on_reset_n; // RULE_04

  // register index from address bits 6..2 only
  assign acc_port = idx_port(paddr); // RULE_11
  assign acc_field = idx_field(paddr); // RULE_11

  // write taken once, on the first clock of a selected write strobe
  assign wr_take = psel & pstb & ~pstb_q & pwrite; // RULE_14 RULE_15

  assign pin_raw[0] = port_a_in_lines;
  assign pin_raw[1] = port_b_in_lines;
  assign pin_raw[2] = port_c_in_lines;
  assign pin_raw[3] = port_d_in_lines;

  // strobe history for write edge detection
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pstb_q <= 1'b0;
    end else begin
      pstb_q <= pstb;
    end
  end

  for (genvar p = 0; p < 4; p++) begin : g_port
    // two-stage pin synchroniser
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        pin_s1[p] <= 8'h00;
        pin_s2[p] <= 8'h00;
      end else begin
        pin_s1[p] <= pin_raw[p]; // RULE_20
        pin_s2[p] <= pin_s1[p];
      end
    end

    // data and direction registers
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        data_q[p] <= `AFPG_RST_DATA;
        dir_q[p] <= `AFPG_RST_DIR; // RULE_16
      end else if (wr_take && acc_port == 2'(p)) begin
        if (acc_field == `AFPG_FLD_DATA) begin
          data_q[p] <= pdata_in; // RULE_01
        end
        if (acc_field == `AFPG_FLD_DIR) begin
          dir_q[p] <= pdata_in; // RULE_01
        end
      end
    end

    // interrupt configuration registers
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        mask_q[p] <= `AFPG_RST_MASK;
        edge_q[p] <= `AFPG_RST_EDGE;
        pol_q[p] <= `AFPG_RST_POL;
      end else if (wr_take && acc_port == 2'(p)) begin
        if (acc_field == `AFPG_FLD_MASK) begin
          mask_q[p] <= pdata_in;
        end
        if (acc_field == `AFPG_FLD_EDGE) begin
          edge_q[p] <= pdata_in;
        end
        if (acc_field == `AFPG_FLD_POL) begin
          pol_q[p] <= pdata_in;
        end
      end
    end

    // write-only clear, held for one cycle then self-cleared
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        clr_q[p] <= 8'h00;
      end else if (wr_take && acc_port == 2'(p) && acc_field == `AFPG_FLD_CLEAR) begin
        clr_q[p] <= pdata_in; // RULE_17
      end else begin
        clr_q[p] <= 8'h00;
      end
    end

    // multi-function select, only the shared bits exist
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        alt_q[p] <= `AFPG_RST_ALT;
      end else if (wr_take && acc_port == 2'(p) && acc_field == `AFPG_FLD_ALT) begin
        alt_q[p] <= pdata_in & alt_bits(2'(p)); // RULE_09
      end
    end

    // pins usable as general io: unshared bits, or shared bits selected
    assign gpio_sel[p] = ~alt_bits(2'(p)) | alt_q[p]; // RULE_09

    // pad drivers: data out, enables low only for selected output pins
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        out_q[p] <= `AFPG_RST_DATA;
        oen_q[p] <= `AFPG_RST_DIR; // RULE_04
      end else begin
        out_q[p] <= data_q[p]; // RULE_05
        oen_q[p] <= dir_q[p] | ~gpio_sel[p]; // RULE_03 RULE_06
      end
    end

    // interrupt logic; only selected input pins take part
    afpg_port_irq u_irq (
      .sys_clk(sys_clk),
      .srst(rst),
      .pin_sync(pin_s2[p]),
      .is_input(dir_q[p] & gpio_sel[p]), // RULE_08
      .mask(mask_q[p]),
      .edge_mode(edge_q[p]),
      .polarity(pol_q[p]),
      .clear_pulse(clr_q[p]),
      .status(stat[p]),
      .irq(irq_w[p])
    );
  end

  // read data selection; unmapped and write-only fields read zero
  always_comb begin
    next_rdata = 8'h00;
    unique case (acc_field)
      `AFPG_FLD_DATA: next_rdata = pin_s2[acc_port]; // RULE_02 RULE_07
      `AFPG_FLD_DIR: next_rdata = dir_q[acc_port];
      `AFPG_FLD_MASK: next_rdata = mask_q[acc_port];
      `AFPG_FLD_STATUS: next_rdata = stat[acc_port];
      `AFPG_FLD_EDGE: next_rdata = edge_q[acc_port];
      `AFPG_FLD_CLEAR: next_rdata = 8'h00;
      `AFPG_FLD_POL: next_rdata = pol_q[acc_port];
      `AFPG_FLD_ALT: next_rdata = alt_q[acc_port];
    endcase
  end

  // data bus: registered, driven in the cycle after each clock of a selected read strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pdata_out <= 8'h00;
      pdata_oe <= 1'b0;
    end else begin
      pdata_out <= (psel && pstb && !pwrite) ? next_rdata : 8'h00; // RULE_10
      pdata_oe <= psel & pstb & ~pwrite; // RULE_10 RULE_15
    end
  end

  // per-port request lines
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_q <= 4'h0;
    end else begin
      irq_q <= irq_w; // RULE_19
    end
  end

  assign port_a_out_lines = out_q[0];
  assign port_b_out_lines = out_q[1];
  assign port_c_out_lines = out_q[2];
  assign port_d_out_lines = out_q[3];
  assign port_a_drive_en_n = oen_q[0];
  assign port_b_drive_en_n = oen_q[1];
  assign port_c_drive_en_n = oen_q[2];
  assign port_d_drive_en_n = oen_q[3];
  assign port_a_irq = irq_q[0];
  assign port_b_irq = irq_q[1];
  assign port_c_irq = irq_q[2];
  assign port_d_irq = irq_q[3];
endmodule

// File: afpg_map.svh
// register offsets, field positions, reset values for the four port gpio
// assumes: included by the top module and the testbench by bare name
//
// What this block does
// RULE_01 - each port: data and direction registers
// RULE_02 - data read returns sampled pin state
// RULE_03 - data write drives only output pins
// RULE_04 - reset makes every pin an input
// RULE_05 - stored data goes to output lines
// RULE_06 - direction bits drive active-low enables
// RULE_07 - input lines shown on data reads
// RULE_08 - unmasked input pins raise selectable interrupts
// RULE_09 - multi-function pins need select bit set
// RULE_10 - drive data bus only on reads
// RULE_11 - decode registers from address bits 6..2
// RULE_12 - bridge holds address, write around strobe
// RULE_13 - bridge times accesses with the strobe
// RULE_14 - write high writes, low reads
// RULE_15 - respond only while select is high
// RULE_16 - direction set is input, reset sets all
// RULE_17 - clear register drops edge requests, self-clears
// RULE_18 - masked pin status reads zero
// RULE_19 - level active-high request per port
// RULE_20 - synchronise pins before use
`ifndef AFPG_MAP_SVH
`define AFPG_MAP_SVH

// word index = port * 8 + field, port a..d = 0..3
`define AFPG_FLD_DATA 3'h0
`define AFPG_FLD_DIR 3'h1
`define AFPG_FLD_MASK 3'h2
`define AFPG_FLD_STATUS 3'h3
`define AFPG_FLD_EDGE 3'h4
`define AFPG_FLD_CLEAR 3'h5
`define AFPG_FLD_POL 3'h6
`define AFPG_FLD_ALT 3'h7

// port numbers carrying multi-function pins
`define AFPG_PORT_B 2'h1
`define AFPG_PORT_D 2'h3

// reset values
`define AFPG_RST_DATA 8'h00
`define AFPG_RST_DIR 8'hFF
`define AFPG_RST_MASK 8'h00
`define AFPG_RST_EDGE 8'h00
`define AFPG_RST_POL 8'h00
`define AFPG_RST_ALT 8'h00

// bits of port b and port d shared with other functions
`define AFPG_ALT_MASK_B 8'h3F
`define AFPG_ALT_MASK_D 8'h0F

`endif

// File: afpg_pkg.sv
// types shared by the four port gpio modules
// assumes: nothing beyond the map header
package afpg_pkg;
  typedef logic [7:0] afpg_byte_t;
  typedef logic [1:0] afpg_port_t;
  typedef logic [2:0] afpg_field_t;
  typedef logic [4:0] afpg_index_t;
endpackage

// File: afpg_port_irq.sv
// interrupt logic of one 8-bit port: trigger, edge latch, status, request
// assumes: pin inputs already synchronised to sys_clk
`timescale 1ns/1ps
module afpg_port_irq (
  input wire logic sys_clk,
  input wire logic srst,
  input wire afpg_pkg::afpg_byte_t pin_sync,
  input wire afpg_pkg::afpg_byte_t is_input,
  input wire afpg_pkg::afpg_byte_t mask,
  input wire afpg_pkg::afpg_byte_t edge_mode,
  input wire afpg_pkg::afpg_byte_t polarity,
  input wire afpg_pkg::afpg_byte_t clear_pulse,
  output afpg_pkg::afpg_byte_t status,
  output logic irq
);
  afpg_pkg::afpg_byte_t active;
  afpg_pkg::afpg_byte_t active_q;
  afpg_pkg::afpg_byte_t latch;
  afpg_pkg::afpg_byte_t next_status;

  // trigger level after polarity, only for pins set as inputs
  assign active = (pin_sync ^ polarity) & is_input; // RULE_08

  // previous trigger level for edge detection
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      active_q <= 8'h00;
    end else begin
      active_q <= active;
    end
  end

  // sticky edge request, a new edge wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      latch <= 8'h00;
    end else begin
      latch <= (latch & ~clear_pulse) | (active & ~active_q); // RULE_17
    end
  end

  // level pins follow the trigger, edge pins the latch; masked bits read zero
  assign next_status = mask & ((edge_mode & latch) | (~edge_mode & active)); // RULE_18

  // registered status and one active-high level request
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      status <= 8'h00;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      irq <= |next_status; // RULE_19
    end
  end
endmodule

// File: afpg_chk.sv
// bus and port checker for the four port gpio
// assumes: bound to afpg_top, one clock, strobe-timed accesses
`timescale 1ns/1ps
module afpg_chk (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic power_on_reset_n,
  input wire logic psel,
  input wire logic pstb,
  input wire logic pwrite,
  input wire logic [6:2] paddr,
  input wire logic [7:0] pdata_in,
  input wire logic [7:0] pdata_out,
  input wire logic pdata_oe,
  input wire logic [7:0] port_a_out_lines,
  input wire logic [7:0] port_a_drive_en_n,
  input wire logic [7:0] port_a_in_lines,
  input wire logic [7:0] port_c_drive_en_n,
  input wire logic port_a_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst || !power_on_reset_n);
  // selected read and write strobes
  wire logic rd = psel && pstb && !pwrite;
  wire logic wr = psel && pstb && pwrite;
  read_oe_on_a: assert property (rd |=> pdata_oe)
    else $error("bus not driven after read");
  read_oe_off_a: assert property (!rd |=> !pdata_oe)
    else $error("bus driven outside read");
  idle_bus_a: assert property (!pdata_oe |-> pdata_out == 8'h00)
    else $error("data not zero while idle");
  clear_reads_zero_a: assert property (rd && paddr[4:2] == 3'h5 |=> pdata_out == 8'h00)
    else $error("clear field read not zero");
  data_drive_a: assert property (
    wr && !$past(pstb) && paddr == 5'h00 |-> ##3 port_a_out_lines == $past(pdata_in, 3))
    else $error("port a lines wrong");
  dir_enable_a: assert property (
    wr && !$past(pstb) && paddr == 5'h11 |-> ##3 port_c_drive_en_n == $past(pdata_in, 3))
    else $error("port c enables wrong");
  pin_read_a: assert property (
    $stable(port_a_in_lines) [*4] ##0 (rd && paddr == 5'h00)
    |=> pdata_out == $past(port_a_in_lines))
    else $error("pin read wrong");
  reset_state_a: assert property (disable iff (1'b0)
    srst || !power_on_reset_n |=> !pdata_oe && !port_a_irq
    && port_a_drive_en_n == 8'hFF && port_a_out_lines == 8'h00)
    else $error("reset state wrong");
endmodule
bind afpg_top afpg_chk i_afpg_chk (.sys_clk, .srst, .power_on_reset_n, .psel, .pstb,
  .pwrite, .paddr, .pdata_in, .pdata_out, .pdata_oe, .port_a_out_lines,
  .port_a_drive_en_n, .port_a_in_lines, .port_c_drive_en_n, .port_a_irq);

// File: afpg_bridge.sv
// peripheral bus bridge model issuing strobe-timed accesses
// assumes: block answers one cycle after the strobe is seen
`timescale 1ns/1ps
module afpg_bridge (
  input wire logic sys_clk,
  input wire logic [7:0] pdata_out,
  output logic psel,
  output logic pstb,
  output logic pwrite,
  output logic [6:2] paddr,
  output logic [7:0] pdata_in
);
  // idle bus at power-up
  initial begin
    psel = 1'b0;
    pstb = 1'b0;
    pwrite = 1'b0;
    paddr = 5'h00;
    pdata_in = 8'h00;
  end
  // one access, strobe held len cycles, address kept past its fall
  task automatic xfer(input logic s, w, input logic [4:0] a, input logic [7:0] d,
    input int len, output logic [7:0] q);
    @(negedge sys_clk);
    psel = s;
    pwrite = w;
    paddr = a;
    pdata_in = w ? d : ~pdata_in;
    pstb = 1'b1;
    repeat (len) @(negedge sys_clk);
    q = pdata_out;
    pstb = 1'b0;
  endtask
endmodule

// File: apb_four_port_gpio_tb.sv
// self-checking bench of the four port gpio: registers, pads, interrupts
// assumes: afpg_top, afpg_bridge model, afpg_chk bound to the top
`timescale 1ns/1ps
`include "afpg_map.svh"
module apb_four_port_gpio_tb;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic power_on_reset_n = 1'b1;
  logic psel, pstb, pwrite, pdata_oe;
  logic [6:2] paddr;
  logic [7:0] pdata_in, pdata_out, q, e;
  logic [7:0] out_l [4], en_n [4], in_l [4], dat_m [4], dir_m [4], alt_m [4];
  logic [7:0] ext [4] = '{default: 8'h00};
  logic [3:0] irq;
  int p;
  int n_fail = 0;
  int n_compared = 0;
  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;
  // pads: enabled bits show the output, the rest the outside level
  always_comb for (int k = 0; k < 4; k++) in_l[k] = (out_l[k] & ~en_n[k]) | (ext[k] & en_n[k]);
  afpg_top i_afpg_top (.sys_clk, .srst, .power_on_reset_n, .psel, .pstb, .pwrite, .paddr,
    .pdata_in, .pdata_out, .pdata_oe,
    .port_a_out_lines(out_l[0]), .port_a_drive_en_n(en_n[0]), .port_a_in_lines(in_l[0]),
    .port_b_out_lines(out_l[1]), .port_b_drive_en_n(en_n[1]), .port_b_in_lines(in_l[1]),
    .port_c_out_lines(out_l[2]), .port_c_drive_en_n(en_n[2]), .port_c_in_lines(in_l[2]),
    .port_d_out_lines(out_l[3]), .port_d_drive_en_n(en_n[3]), .port_d_in_lines(in_l[3]),
    .port_a_irq(irq[0]), .port_b_irq(irq[1]), .port_c_irq(irq[2]), .port_d_irq(irq[3]));
  afpg_bridge i_afpg_bridge (.sys_clk, .pdata_out, .psel, .pstb, .pwrite, .paddr, .pdata_in);
  // bits of a port shared with other functions
  function automatic logic [7:0] amask(input int k);
    return k == 1 ? `AFPG_ALT_MASK_B : k == 3 ? `AFPG_ALT_MASK_D : 8'h00;
  endfunction
  // expected enables: direction, held off on unselected shared bits
  function automatic logic [7:0] exp_en(input int k);
    return dir_m[k] | (amask(k) & ~alt_m[k]);
  endfunction
  task automatic check(input string nm, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    i_afpg_bridge.xfer(1'b1, 1'b1, a, d, $urandom_range(3, 1), q);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] x);
    i_afpg_bridge.xfer(1'b1, 1'b0, a, 8'h00, $urandom_range(2, 1), q);
    check($sformatf("reg %h", a), q, x);
  endtask
  task automatic irq_chk(input logic v);
    repeat (6) @(negedge sys_clk);
    check("irq c", {7'h00, irq[2]}, {7'h00, v});
  endtask
  // reset state of every port and of each register except the data register, which is not read back
  task automatic chk_rst();
    for (int k = 0; k < 4; k++) begin
      dat_m[k] = 8'h00;
      dir_m[k] = 8'hFF;
      alt_m[k] = 8'h00;
      check("drive_en_n", en_n[k], 8'hFF);
      check("out_lines", out_l[k], 8'h00);
      for (int f = 1; f < 8; f++) rdc({k[1:0], f[2:0]}, f == 1 ? 8'hFF : 8'h00);
    end
  endtask
  // main sequence
  initial begin
    void'($urandom(82100));
    repeat (5) @(negedge sys_clk);
    srst = 1'b0;
    chk_rst();
    // random port setups, the first with every direction bit set to output
    for (int i = 0; i < 40; i++) begin
      p = $urandom_range(3, 0);
      dat_m[p] = $urandom;
      dir_m[p] = i == 0 ? 8'h00 : 8'($urandom);
      e = $urandom;
      wr({p[1:0], 3'h0}, dat_m[p]);
      wr({p[1:0], 3'h1}, dir_m[p]);
      wr({p[1:0], 3'h7}, e);
      alt_m[p] = e & amask(p);
      ext[p] = $urandom;
      repeat (4) @(negedge sys_clk);
      e = exp_en(p);
      check("out_lines", out_l[p], dat_m[p]);
      check("drive_en_n", en_n[p], e);
      rdc({p[1:0], 3'h0}, (dat_m[p] & ~e) | (ext[p] & e));
      rdc({p[1:0], 3'h7}, alt_m[p]);
    end
    // a write without select is ignored
    i_afpg_bridge.xfer(1'b0, 1'b1, 5'h11, ~dir_m[2], 1, q);
    rdc(5'h11, dir_m[2]);
    // port c bit 0: masked, both levels, then edge with clear
    wr(5'h11, 8'hFF);
    wr(5'h12, 8'h00);
    ext[2] = 8'h01;
    irq_chk(1'b0);
    rdc(5'h13, 8'h00);
    wr(5'h12, 8'h01);
    irq_chk(1'b1);
    rdc(5'h13, 8'h01);
    wr(5'h16, 8'h01);
    irq_chk(1'b0);
    ext[2] = 8'h00;
    irq_chk(1'b1);
    wr(5'h16, 8'h00);
    wr(5'h14, 8'h01);
    wr(5'h15, 8'h01);
    irq_chk(1'b0);
    ext[2] = 8'h01;
    irq_chk(1'b1);
    ext[2] = 8'h00;
    irq_chk(1'b1);
    wr(5'h15, 8'h01);
    irq_chk(1'b0);
    rdc(5'h15, 8'h00);
    // power-on reset in mid-run
    power_on_reset_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    power_on_reset_n = 1'b1;
    chk_rst();
    check("irq", {4'h0, irq}, 8'h00);
    stop_test();
  end
  // cuts a hang short
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    stop_test();
  end
endmodule
